// file: design/tape_deskew_consts.svh
`ifndef TAPE_DESKEW_CONSTS_SVH
`define TAPE_DESKEW_CONSTS_SVH
// Nine tracks: bits 7..0 data, bit 8 parity
`define TRK_N        9
`define TRK_PAR      8
// Skew store depth and output buffer depth
`define SKEW_DEPTH   4
`define OUT_DEPTH    2
// First chain half holds tracks 0..4
`define CHAIN_SPLIT  5
// Character FIFO geometry, word is 9 data bits plus two flags
`define CF_WIDTH     11
`define CF_DEPTH     16
`define CF_AW        4
// Field positions inside a FIFO word
`define CF_PERR_BIT  9
`define CF_CORR_BIT  10
// Reset values
`define PTR_RST      4'h0
`define SKEW_RST     4'h0
`define TRK_RST      9'h000
// Number of transfers before the second output stage holds data
`define FILL_CNT     2'h2
`endif

// file: design/tape_deskew_pkg.sv
package tape_deskew_pkg;
  typedef logic [8:0]  track_vec_t;
  typedef logic [3:0]  nibble_t;
  typedef logic [10:0] char_word_t;
  typedef enum logic [1:0] {
    CORR_IDLE,
    CORR_ARMED,
    CORR_RUN
  } corr_state_t;
endpackage

// file: design/tape_track_deskew_correct.sv
// Overview of operation
// - Nine tracks, four-stage skew, two output stages
// - One-hot pointer marks next write stage
// - Bit strobe selects left shift one clock
// - Window low or lost high holds left select
// - Left pulse unless copy, loads seed
// - Copy shifts all right, zeros in top
// - Assembled when all pointers left bottom
// - Write at top stage flags overflow
// - Postamble pattern 10, lost tracks pass
// - Postamble sampled at each copy transfer
// - Window and preamble-end both low clear skew stores
// - Seed pulse loads pointer bottom stage
// - Bits fill stages as pointer advances
// - Window fall returns buffer to idle
// - Odd parity check, single-track regeneration
// - Inverted second stage ORed correction, strobe
// - Lost blocks ones, clears preamble-end, stores
// - Lost track flushed, passes postamble, corrects
// - Single dropout corrects from next transfer
// - Indicator shows correction in progress
// - Any-lost and multi-lost outputs
// - Multi-lost built as two half chains
// - Synced strobe is strobe gated preamble-end
// - Lost flag armed only while enabled
`timescale 1ns/1ns
`include "tape_deskew_consts.svh"

module char_fifo #(
  parameter int WIDTH = `CF_WIDTH,
  parameter int DEPTH = `CF_DEPTH,
  parameter int AW    = `CF_AW
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Honest full and empty from occupancy
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage write
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule // char_fifo

module tape_track_deskew_correct (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_b_i,
  input  wire tape_deskew_pkg::track_vec_t cell_data_strobe_i,
  input  wire tape_deskew_pkg::track_vec_t cell_bit_one_i,
  input  wire tape_deskew_pkg::track_vec_t dropout_detect_i,
  input  wire logic                        lost_arm_i,
  input  wire logic                        sync_window_enable_i,
  input  wire logic                        pointer_seed_i,
  input  wire logic                        copy_char_n_i,
  input  wire logic                        host_ready_i,
  output      logic                        all_tracks_assembled_o,
  output      logic                        postamble_found_o,
  output      logic                        postamble_seen_o,
  output      logic                        skew_overflow_n_o,
  output      logic                        any_track_lost_o,
  output      logic                        multi_track_lost_n_o,
  output      tape_deskew_pkg::track_vec_t track_lost_n_o,
  output      logic                        char_buffer_ready_o,
  output      logic [7:0]                  out_data_lines_o,
  output      logic                        out_parity_line_o,
  output      logic                        char_out_strobe_o,
  output      logic                        read_parity_error_o,
  output      logic                        correcting_indicator_o
);
  import tape_deskew_pkg::*;

  track_vec_t  lost_q;
  track_vec_t  pre_end_q;
  nibble_t     ptr_q  [`TRK_N];
  nibble_t     skew_q [`TRK_N];
  track_vec_t  d1_q;
  track_vec_t  d2_q;
  track_vec_t  synced_bit_strobe;
  track_vec_t  shift_left_select;
  track_vec_t  left_shift_pulse;
  track_vec_t  bit_one;
  track_vec_t  ptr_low;
  track_vec_t  post_ok;
  track_vec_t  corr_gate;
  track_vec_t  out_char;
  logic        right_shift_pulse;
  logic        overflow_q;
  logic        overflow_now;
  logic        post_seen_q;
  logic [1:0]  fill_q;
  logic        push_q;
  logic        parity_fix_bit;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  char_word_t  fifo_in;
  char_word_t  fifo_out;
  char_word_t  out_q;
  logic        strobe_q;
  logic        single_lost;
  corr_state_t corr_q;

  // Two-half chain: pass OR of lost flags, collect pairwise overlaps
  function automatic logic [1:0] lost_chain(input track_vec_t lost, input int lo,
                                            input int hi);
    logic up;
    logic multi;
    up    = 1'b0;
    multi = 1'b0;
    for (int i = lo; i <= hi; i++) begin
      multi = multi | (up & lost[i]);
      up    = up | lost[i];
    end
    return {multi, up};
  endfunction

  // Odd parity regeneration of one track from the other eight
  function automatic logic regen_bit(input track_vec_t chr, input track_vec_t lost);
    return ~^(chr & ~lost);
  endfunction

  logic [1:0] chain_a;
  logic [1:0] chain_b;

  // Dropout summary outputs
  always_comb begin
    chain_a              = lost_chain(lost_q, 0, `CHAIN_SPLIT - 1);
    chain_b              = lost_chain(lost_q, `CHAIN_SPLIT, `TRK_N - 1);
    any_track_lost_o     = chain_a[0] | chain_b[0];
    multi_track_lost_n_o = ~(chain_a[1] | chain_b[1] | (chain_a[0] & chain_b[0]));
  end

  assign single_lost    = any_track_lost_o & multi_track_lost_n_o;
  assign track_lost_n_o = ~lost_q;

  // Lost flags, armed only inside the enable interval
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lost_q <= `TRK_RST;
    end else if (!lost_arm_i) begin
      lost_q <= `TRK_RST;
    end else begin
      lost_q <= lost_q | dropout_detect_i;
    end
  end

  // Per-track strobe and select terms
  always_comb begin
    for (int t = 0; t < `TRK_N; t++) begin
      bit_one[t]           = cell_bit_one_i[t] & ~lost_q[t];
      synced_bit_strobe[t] = cell_data_strobe_i[t] & pre_end_q[t] & ~lost_q[t];
      shift_left_select[t] = synced_bit_strobe[t] | ~sync_window_enable_i
                             | lost_q[t];
      left_shift_pulse[t]  = shift_left_select[t] & copy_char_n_i;
      ptr_low[t]           = ptr_q[t][0];
      post_ok[t]           = lost_q[t] | (d1_q[t] & ~skew_q[t][0]);
    end
  end

  assign right_shift_pulse      = ~copy_char_n_i;
  assign all_tracks_assembled_o = ~|ptr_low;
  assign postamble_found_o      = &post_ok;
  assign overflow_now           = |(synced_bit_strobe & {ptr_q[8][3], ptr_q[7][3],
                                   ptr_q[6][3], ptr_q[5][3], ptr_q[4][3], ptr_q[3][3],
                                   ptr_q[2][3], ptr_q[1][3], ptr_q[0][3]});
  assign skew_overflow_n_o      = ~overflow_q;

  // Preamble-end flags: first one bit inside the window
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_end_q <= `TRK_RST;
    end else begin
      for (int t = 0; t < `TRK_N; t++) begin
        if (!sync_window_enable_i || lost_q[t]) begin
          pre_end_q[t] <= 1'b0;
        end else if (cell_data_strobe_i[t] && bit_one[t]) begin
          pre_end_q[t] <= 1'b1;
        end
      end
    end
  end

  // Pointer registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int t = 0; t < `TRK_N; t++) begin
        ptr_q[t] <= `PTR_RST;
      end
    end else begin
      for (int t = 0; t < `TRK_N; t++) begin
        if (right_shift_pulse) begin
          ptr_q[t] <= {1'b0, ptr_q[t][3:1]};
        end else if (left_shift_pulse[t]) begin
          ptr_q[t] <= {ptr_q[t][2:0], pointer_seed_i};
        end
      end
    end
  end

  // Skew stores: write the marked stage, shift in the same clock
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int t = 0; t < `TRK_N; t++) begin
        skew_q[t] <= `SKEW_RST;
      end
    end else begin
      for (int t = 0; t < `TRK_N; t++) begin
        nibble_t wr;
        wr = skew_q[t];
        if (synced_bit_strobe[t]) begin
          for (int s = 0; s < `SKEW_DEPTH; s++) begin
            if (ptr_q[t][s]) begin
              wr[s] = bit_one[t];
            end
          end
        end
        if (!pre_end_q[t] && !sync_window_enable_i) begin
          skew_q[t] <= `SKEW_RST;
        end else if (lost_q[t]) begin
          skew_q[t] <= `SKEW_RST;
        end else if (right_shift_pulse) begin
          skew_q[t] <= {1'b0, wr[3:1]};
        end else begin
          skew_q[t] <= wr;
        end
      end
    end
  end

  // Output stages: first stage follows track state, second only the window
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      d1_q <= `TRK_RST;
      d2_q <= `TRK_RST;
    end else begin
      for (int t = 0; t < `TRK_N; t++) begin
        if (!sync_window_enable_i || lost_q[t]) begin
          d1_q[t] <= 1'b0;
        end else if (right_shift_pulse) begin
          d1_q[t] <= skew_q[t][0];
        end
      end
      if (!sync_window_enable_i) begin
        d2_q <= `TRK_RST;
      end else if (right_shift_pulse) begin
        d2_q <= d1_q;
      end
    end
  end

  // Sticky overflow and postamble sample, dropped when window falls
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_q  <= 1'b0;
      post_seen_q <= 1'b0;
    end else if (!sync_window_enable_i) begin
      overflow_q  <= 1'b0;
      post_seen_q <= 1'b0;
    end else begin
      if (overflow_now) begin
        overflow_q <= 1'b1;
      end
      if (right_shift_pulse && postamble_found_o) begin
        post_seen_q <= 1'b1;
      end
    end
  end

  assign postamble_seen_o = post_seen_q;

  // Correction sequencer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      corr_q <= CORR_IDLE;
    end else if (!sync_window_enable_i || post_seen_q) begin
      corr_q <= CORR_IDLE;
    end else begin
      case (corr_q)
        CORR_IDLE: begin
          if (single_lost && !overflow_q) begin
            corr_q <= CORR_ARMED;
          end
        end
        CORR_ARMED: begin
          if (!single_lost || overflow_q) begin
            corr_q <= CORR_IDLE;
          end else if (right_shift_pulse) begin
            corr_q <= CORR_RUN;
          end
        end
        CORR_RUN: begin
          if (!single_lost || overflow_q) begin
            corr_q <= CORR_IDLE;
          end
        end
        default: begin
          corr_q <= CORR_IDLE;
        end
      endcase
    end
  end

  assign correcting_indicator_o = (corr_q == CORR_RUN);

  // Corrected character from second stage
  always_comb begin
    parity_fix_bit = regen_bit(d2_q, lost_q);
    corr_gate      = correcting_indicator_o ? lost_q : `TRK_RST;
    out_char       = d2_q | (corr_gate & {`TRK_N{parity_fix_bit}});
    fifo_in        = {correcting_indicator_o,
                      ~any_track_lost_o & ~(^d2_q),
                      out_char};
  end

  // Count transfers so only real characters leave the second stage
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fill_q <= 2'h0;
      push_q <= 1'b0;
    end else begin
      push_q <= right_shift_pulse && (fill_q == `FILL_CNT - 2'h1 || fill_q == `FILL_CNT)
                && sync_window_enable_i && !postamble_found_o;
      if (!sync_window_enable_i) begin
        fill_q <= 2'h0;
      end else if (right_shift_pulse && fill_q != `FILL_CNT) begin
        fill_q <= fill_q + 2'h1;
      end
    end
  end

  assign char_buffer_ready_o = fifo_in_ready;

  char_fifo #(
    .WIDTH (`CF_WIDTH),
    .DEPTH (`CF_DEPTH),
    .AW    (`CF_AW)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (host_ready_i),
    .out_data_o  (fifo_out)
  );

  assign fifo_pop = fifo_out_valid & host_ready_i;

  // Host side: latched word and one strobe per character
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_q    <= '0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= fifo_pop;
      if (fifo_pop) begin
        out_q <= fifo_out;
      end
    end
  end

  // Read lines are active low: inverted stored data
  assign out_data_lines_o       = ~out_q[7:0];
  assign out_parity_line_o      = ~out_q[`TRK_PAR];
  assign char_out_strobe_o      = strobe_q;
  assign read_parity_error_o    = out_q[`CF_PERR_BIT];
endmodule // tape_track_deskew_correct

// file: verif/tape_deskew_sva.sv
`timescale 1ns/1ns
module tape_deskew_sva (
  input wire logic                        mclk_i,
  input wire logic                        rst_b_i,
  input wire tape_deskew_pkg::track_vec_t dropout_detect_i,
  input wire logic                        lost_arm_i,
  input wire logic                        sync_window_enable_i,
  input wire logic                        copy_char_n_i,
  input wire logic                        postamble_found_o,
  input wire logic                        postamble_seen_o,
  input wire logic                        skew_overflow_n_o,
  input wire logic                        any_track_lost_o,
  input wire logic                        multi_track_lost_n_o,
  input wire tape_deskew_pkg::track_vec_t track_lost_n_o
);
  import tape_deskew_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Copy taken while the postamble pattern shows
  sequence s_post_copy;
    !copy_char_n_i && postamble_found_o && sync_window_enable_i;
  endsequence
  // Dropout seen while armed and in the window
  sequence s_drop_armed;
    lost_arm_i && sync_window_enable_i && (|dropout_detect_i);
  endsequence
  chk_post_seen: assert property (s_post_copy |=> postamble_seen_o)
    else $error("postamble not latched at copy");
  chk_seen_hold: assert property (postamble_seen_o && sync_window_enable_i |=> postamble_seen_o)
    else $error("postamble flag dropped early");
  chk_window_clear: assert property (!sync_window_enable_i |=> !postamble_seen_o && skew_overflow_n_o)
    else $error("window low did not clear flags");
  chk_ovf_sticky: assert property (!skew_overflow_n_o && sync_window_enable_i |=> !skew_overflow_n_o)
    else $error("overflow flag not sticky");
  chk_lost_set: assert property (s_drop_armed |=> (track_lost_n_o & $past(dropout_detect_i)) == '0)
    else $error("lost flag did not set");
  chk_lost_clear: assert property (!lost_arm_i |=> track_lost_n_o == 9'h1ff)
    else $error("lost flags not cleared");
  chk_any_lost: assert property (any_track_lost_o == (track_lost_n_o != 9'h1ff))
    else $error("any-lost wrong");
  chk_multi_lost: assert property (multi_track_lost_n_o == ($countones(~track_lost_n_o) < 2))
    else $error("multi-lost wrong");
endmodule // tape_deskew_sva

bind tape_track_deskew_correct tape_deskew_sva u_sva (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .dropout_detect_i(dropout_detect_i),
  .lost_arm_i(lost_arm_i), .sync_window_enable_i(sync_window_enable_i),
  .copy_char_n_i(copy_char_n_i), .postamble_found_o(postamble_found_o),
  .postamble_seen_o(postamble_seen_o), .skew_overflow_n_o(skew_overflow_n_o),
  .any_track_lost_o(any_track_lost_o), .multi_track_lost_n_o(multi_track_lost_n_o),
  .track_lost_n_o(track_lost_n_o)
);

// file: verif/host_ctrl_model.sv
`timescale 1ns/1ns
module host_ctrl_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       stall_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] lines_i,
  input  wire logic       par_line_i,
  input  wire logic       strobe_i,
  input  wire logic       perr_i,
  output      logic       host_ready_o
);
  logic [9:0] rx_q[$];
  logic       phase_q;
  // Pacing phase for the slow host
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end
  assign host_ready_o = !stall_i && (!slow_i || phase_q);
  // Latch the active-low lines on each strobe
  always @(posedge mclk_i) begin
    if (strobe_i === 1'b1) begin
      rx_q.push_back({perr_i, ~par_line_i, ~lines_i});
    end
  end
endmodule // host_ctrl_model

// file: verif/tb_tape_track_deskew_correct.sv
`timescale 1ns/1ns
module tb_tape_track_deskew_correct;
  import tape_deskew_pkg::*;
  logic       mclk_i, rst_b_i, lost_arm_i, sync_window_enable_i;
  logic       pointer_seed_i, copy_char_n_i, stall, slow;
  track_vec_t cell_data_strobe_i, cell_bit_one_i, dropout_detect_i, lm;
  wire logic  host_ready_i, assembled, post_found, post_seen, ovf_n, any_lost, multi_n;
  wire logic  buf_rdy, par_line, strobe, perr, corr;
  wire logic [7:0] lines;
  track_vec_t lost_n;
  logic [9:0] sent_q[$];
  int         err_count, n_compared, cyc, n, tr;

  tape_track_deskew_correct dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cell_data_strobe_i(cell_data_strobe_i),
    .cell_bit_one_i(cell_bit_one_i), .dropout_detect_i(dropout_detect_i),
    .lost_arm_i(lost_arm_i), .sync_window_enable_i(sync_window_enable_i),
    .pointer_seed_i(pointer_seed_i), .copy_char_n_i(copy_char_n_i),
    .host_ready_i(host_ready_i), .all_tracks_assembled_o(assembled),
    .postamble_found_o(post_found), .postamble_seen_o(post_seen),
    .skew_overflow_n_o(ovf_n), .any_track_lost_o(any_lost),
    .multi_track_lost_n_o(multi_n), .track_lost_n_o(lost_n),
    .char_buffer_ready_o(buf_rdy), .out_data_lines_o(lines), .out_parity_line_o(par_line),
    .char_out_strobe_o(strobe), .read_parity_error_o(perr), .correcting_indicator_o(corr)
  );
  host_ctrl_model host (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .stall_i(stall), .slow_i(slow), .lines_i(lines),
    .par_line_i(par_line), .strobe_i(strobe), .perr_i(perr), .host_ready_o(host_ready_i)
  );

  // Clock and hang guard
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  // Random odd-parity character
  function automatic track_vec_t odd_char();
    logic [7:0] d;
    d = 8'($urandom);
    return {~^d, d};
  endfunction
  // Expected host word: parity error only with no track lost and even parity
  function automatic logic [9:0] exp_word(input track_vec_t c, input track_vec_t lost);
    return {(lost == '0) && !(^c), c};
  endfunction
  // Seed the pointers, open the window, send the last preamble one
  task automatic start_rec();
    sync_window_enable_i = 1'b0;
    wait_n(3);
    pointer_seed_i = 1'b1;
    wait_n(1);
    pointer_seed_i = 1'b0;
    sync_window_enable_i = 1'b1;
    wait_n(1);
    cell_bit_one_i = 9'h1ff;
    cell_data_strobe_i = 9'h1ff;
    wait_n(1);
    cell_data_strobe_i = '0;
    wait_n(1);
  endtask
  // One character with random skew, then copy once assembled
  task automatic send_char(input track_vec_t c, input track_vec_t lost, input bit post);
    int slot[9];
    int w;
    foreach (slot[t]) slot[t] = $urandom_range(2);
    for (int k = 0; k < 3; k++) begin
      foreach (slot[t]) begin
        cell_data_strobe_i[t] = (slot[t] == k);
        cell_bit_one_i[t] = lost[t] ? ~c[t] : c[t];
      end
      wait_n(1);
    end
    cell_data_strobe_i = '0;
    w = 0;
    while (!(assembled === 1'b1 && buf_rdy === 1'b1) && w < 400) begin
      w++;
      wait_n(1);
    end
    check(w < 400, "character never assembled");
    if (post) check(post_found === 1'b1, "postamble pattern missed");
    sent_q.push_back(exp_word(c, lost));
    copy_char_n_i = 1'b0;
    wait_n(1);
    copy_char_n_i = 1'b1;
    wait_n(1);
  endtask
  task automatic cmp_rec(input int cnt);
    check(host.rx_q.size() == cnt, "read char count");
    for (int i = 0; i < cnt; i++) begin
      check(host.rx_q.size() > i && host.rx_q[i] === sent_q[i], "read char");
    end
    host.rx_q.delete();
    sent_q.delete();
  endtask

  initial begin
    void'($urandom(97));
    {rst_b_i, lost_arm_i, sync_window_enable_i, pointer_seed_i, stall, slow} = '0;
    copy_char_n_i = 1'b1;
    {cell_data_strobe_i, cell_bit_one_i, dropout_detect_i} = '0;
    wait_n(16);
    rst_b_i = 1'b1;
    wait_n(1);
    check({lines, par_line, strobe, ovf_n, multi_n, buf_rdy} === 13'h1ff7, "reset");
    // Fill the FIFO against a stalled host, then drain
    stall = 1'b1;
    start_rec();
    n = 0;
    while (buf_rdy === 1'b1 && n < 20) begin
      send_char(odd_char(), '0, 1'b0);
      n++;
    end
    check(n == 17, "FIFO refused at wrong fill");
    stall = 1'b0;
    slow = 1'b1;
    repeat (5) send_char(odd_char(), '0, 1'b0);
    send_char(9'h0f0, '0, 1'b0);
    send_char(9'h1ff, '0, 1'b0);
    send_char(9'h000, '0, 1'b1);
    check(post_seen === 1'b1, "postamble not seen");
    sync_window_enable_i = 1'b0;
    wait_n(2);
    check(post_seen === 1'b0, "window low kept postamble");
    wait_n(150);
    cmp_rec(n + 6);
    // Single dropout corrected, then a second dropout
    slow = 1'b0;
    start_rec();
    lost_arm_i = 1'b1;
    repeat (3) send_char(odd_char(), '0, 1'b0);
    check(corr === 1'b0, "correcting too early");
    tr = $urandom_range(8);
    lm = track_vec_t'(9'h1 << tr);
    dropout_detect_i = lm;
    wait_n(1);
    dropout_detect_i = '0;
    wait_n(1);
    check({lost_n, any_lost, multi_n} === {~lm, 2'b11}, "single lost");
    repeat (6) send_char(odd_char(), lm, 1'b0);
    check(corr === 1'b1, "correction not shown");
    dropout_detect_i = track_vec_t'(9'h1 << ((tr + 1) % 9));
    wait_n(1);
    dropout_detect_i = '0;
    wait_n(1);
    check(multi_n === 1'b0, "multi lost missed");
    lost_arm_i = 1'b0;
    wait_n(2);
    check({lost_n, any_lost} === 10'h3fe, "lost not cleared");
    sync_window_enable_i = 1'b0;
    wait_n(60);
    cmp_rec(8);
    // Skew overflow on one track
    start_rec();
    for (int k = 0; k < 4; k++) begin
      check(ovf_n === 1'b1, "early overflow");
      cell_data_strobe_i = 9'h001;
      cell_bit_one_i = 9'($urandom);
      wait_n(1);
      cell_data_strobe_i = '0;
      wait_n(1);
    end
    wait_n(1);
    check({ovf_n, assembled} === 2'b00, "overflow missed");
    sync_window_enable_i = 1'b0;
    wait_n(8);
    check({ovf_n, assembled} === 2'b11, "window low flush");
    close_out();
  end
endmodule // tb_tape_track_deskew_correct
